// File: shared/twi_pkg.sv
// constants shared by the timer / watchdog / interrupt control block
// assumes one system clock; firmware reaches the registers through a select/strobe port
package twi_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register select codes on the special-register port
  localparam logic [2:0] SEL_TIMER_COUNT = 3'h1;
  localparam logic [2:0] SEL_PORT6_DATA = 3'h2;
  localparam logic [2:0] SEL_PRESCALER = 3'h3;
  localparam logic [2:0] SEL_TIMER_CTRL = 3'h4;
  localparam logic [2:0] SEL_WATCHDOG_CTRL = 3'h5;
  localparam logic [2:0] SEL_IRQ_FLAG = 3'h6;
  localparam logic [2:0] SEL_IRQ_MASK = 3'h7;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_RATIO_LSB = 0;
  localparam int CTRL_ASSIGN_BIT = 3;
  localparam int CTRL_EDGE_BIT = 4;
  localparam int CTRL_SOURCE_BIT = 5;
  localparam int CTRL_GLOBAL_BIT = 6;
  localparam int CTRL_SPARE_BIT = 7;
  localparam int WDC_ENABLE_BIT = 7;
  localparam int WDC_EXT_SEL_BIT = 6;
  localparam int WDC_ROPT_BIT = 4;
  localparam int IRQ_OVERFLOW_BIT = 0;
  localparam int IRQ_PIN_CHANGE_BIT = 1;
  localparam int IRQ_EXT_BIT = 2;

  ////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0] TIMER_CTRL_RESET = 8'hBF;
  localparam logic [7:0] PRESCALER_RESET = 8'hFF;
  localparam logic [7:0] TIMER_COUNT_RESET = 8'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // timing: instruction cycle is two or four oscillator clocks
  localparam int SYS_CLK_PERIOD_NS = 50;
  localparam logic [1:0] CYC_DIV2_LAST = 2'h1;
  localparam logic [1:0] CYC_DIV4_LAST = 2'h3;
  // watchdog base period, nominal figure at 5 V
  localparam int WDT_TIMEOUT_US = 16800;
  // rc oscillator period is not given; plain default
  localparam int WDT_OSC_PERIOD_NS = 1000;
  localparam int WDT_BASE_TICKS = WDT_TIMEOUT_US * 1000 / WDT_OSC_PERIOD_NS;
  localparam int WDT_CNT_W = 24;

  typedef enum logic {ST_RUN, ST_SLEEP} twi_power_type;

endpackage

// File: core/twi_sync2.sv
// two-flop synchroniser for a bundle of pin levels
// assumes each bit is an independent level; multi-bit words need another crossing
`timescale 1ns/1ps
module twi_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// File: core/twi_prescaler.sv
// shared 8-bit down-counting prescaler with a power-of-two tap
// assumes tick and clear are single-cycle pulses in the system clock domain
`timescale 1ns/1ps
module twi_prescaler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic clear,
  input wire logic [3:0] ratio_exp,
  output logic [7:0] count_q,
  output logic period
);

  logic [7:0] count_d;
  logic [8:0] full_mask;
  logic [7:0] mask;

  // a period completes when the tapped low bits are all zero before a step;
  // reloading all ones on clear makes the first period a full one
  always_comb begin
    full_mask = (9'h001 << ratio_exp) - 9'h001;
    mask = full_mask[7:0];
    period = tick && !clear && ((count_q & mask) == 8'h00);
    count_d = count_q;
    if (clear) begin
      count_d = twi_pkg::PRESCALER_RESET;
    end else if (tick) begin
      count_d = count_q - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= twi_pkg::PRESCALER_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  a_clear_reload: assert property (@(posedge clk) disable iff (!rst_n)
    clear |=> count_q == 8'hFF)
    else $error("prescaler not reloaded after clear");

endmodule

// File: core/twi_timer_watchdog.sv
// timer/counter, watchdog, shared prescaler and interrupt control
// assumes CLK_SYS is the oscillator clock and the core drives one-cycle strobes
`timescale 1ns/1ps
module twi_timer_watchdog #(
  parameter int WDT_BASE_TICKS = twi_pkg::WDT_BASE_TICKS
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic [2:0] REG_SEL,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic INSTR_GLOBAL_ON,
  input wire logic INSTR_GLOBAL_OFF,
  input wire logic INSTR_WDT_CLEAR,
  input wire logic INSTR_SLEEP,
  input wire logic IRQ_ACK,
  input wire logic TIMER_PIN,
  input wire logic WDT_OSC,
  input wire logic [7:0] PORT6_PIN,
  input wire logic [1:0] OPTION_PIN,
  input wire logic HW_WDT_OPTION,
  input wire logic CYCLE_DIV4_OPT,
  output logic IRQ_REQ,
  output logic WDT_RESET_REQ,
  output logic WAKE_PULSE,
  output logic WAKE_TO_VECTOR,
  output logic SLEEPING,
  output logic PORT6_PIN0_IRQ_MODE,
  output logic ROPT_ACTIVE,
  output logic [1:0] ROPT_LEVEL
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection
  logic [13:0] pins_s;
  logic timer_pin_s, osc_s, hw_opt_s, div4_s;
  logic [7:0] p6_s;
  logic [1:0] opt_s;
  logic timer_prev_q, osc_prev_q, pin0_prev_q;

  twi_sync2 #(.W(14)) u_sync (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .d({TIMER_PIN, WDT_OSC, PORT6_PIN, OPTION_PIN, HW_WDT_OPTION, CYCLE_DIV4_OPT}),
    .q(pins_s)
  );

  assign {timer_pin_s, osc_s, p6_s, opt_s, hw_opt_s, div4_s} = pins_s;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      timer_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
      pin0_prev_q <= 1'b0;
    end else begin
      timer_prev_q <= timer_pin_s;
      osc_prev_q <= osc_s;
      pin0_prev_q <= p6_s[0];
    end
  end

  logic pin_rise, pin_fall, osc_edge, ext_fall;
  assign pin_rise = timer_pin_s && !timer_prev_q;
  assign pin_fall = !timer_pin_s && timer_prev_q;
  assign osc_edge = osc_s && !osc_prev_q;
  assign ext_fall = !p6_s[0] && pin0_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] ctrl_q, ctrl_d, timer_q, timer_d, rdata_q, rdata_d, p6_ref_q, p6_ref_d;
  logic wde_q, wde_d, xsel_q, xsel_d, roe_q, roe_d, glob_q, glob_d;
  logic [2:0] mask_q, mask_d, flag_q, flag_d, flag_set;
  logic [1:0] cyc_q, cyc_d, ropt_q, ropt_d;
  logic [twi_pkg::WDT_CNT_W-1:0] wdt_q, wdt_d;
  logic wdt_rst_q, wdt_rst_d, wake_q, wake_d, vec_q, vec_d;
  twi_pkg::twi_power_type pwr_q, pwr_d;

  logic wr_timer, wr_ctrl, wr_wdc, wr_flag, wr_mask, rd_port6;
  logic to_wdt, cyc_tick, src_tick, pre_tick, pre_clear, pre_period;
  logic timer_inc, wdt_inc, wdt_on, wdt_clear, wdt_timeout, p6_change;
  logic [3:0] ratio_exp;
  logic [7:0] pre_count;
  logic [twi_pkg::WDT_CNT_W-1:0] wdt_last;

  assign wr_timer = REG_WR && (REG_SEL == twi_pkg::SEL_TIMER_COUNT);
  assign wr_ctrl = REG_WR && (REG_SEL == twi_pkg::SEL_TIMER_CTRL);
  assign wr_wdc = REG_WR && (REG_SEL == twi_pkg::SEL_WATCHDOG_CTRL);
  assign wr_flag = REG_WR && (REG_SEL == twi_pkg::SEL_IRQ_FLAG);
  assign wr_mask = REG_WR && (REG_SEL == twi_pkg::SEL_IRQ_MASK);
  assign rd_port6 = REG_RD && (REG_SEL == twi_pkg::SEL_PORT6_DATA);

  ////////////////////////////////////////////////////////////////////////
  // counting paths
  assign to_wdt = ctrl_q[twi_pkg::CTRL_ASSIGN_BIT];
  assign cyc_tick = (cyc_q == (div4_s ? twi_pkg::CYC_DIV4_LAST : twi_pkg::CYC_DIV2_LAST));
  assign src_tick = ctrl_q[twi_pkg::CTRL_SOURCE_BIT] ?
    (ctrl_q[twi_pkg::CTRL_EDGE_BIT] ? pin_fall : pin_rise) : cyc_tick;
  assign wdt_on = wde_q && hw_opt_s;
  assign wdt_clear = INSTR_WDT_CLEAR || INSTR_SLEEP;
  // the prescaler has one owner at a time; the other counter sees raw ticks
  assign pre_tick = to_wdt ? osc_edge : src_tick;
  assign pre_clear = to_wdt ? wdt_clear : wr_timer;
  // timer taps one step further than the watchdog for the same code
  assign ratio_exp = {1'b0, ctrl_q[2:0]} + {3'h0, !to_wdt};
  assign timer_inc = to_wdt ? src_tick : pre_period;
  assign wdt_inc = wdt_on && (to_wdt ? pre_period : osc_edge);
  assign wdt_last = twi_pkg::WDT_CNT_W'(WDT_BASE_TICKS - 1);
  assign wdt_timeout = wdt_inc && (wdt_q == wdt_last);
  assign p6_change = (p6_s != p6_ref_q);

  twi_prescaler u_pre (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .tick(pre_tick),
    .clear(pre_clear),
    .ratio_exp(ratio_exp),
    .count_q(pre_count),
    .period(pre_period)
  );

  ////////////////////////////////////////////////////////////////////////
  // counters and power state
  always_comb begin
    cyc_d = cyc_tick ? 2'h0 : cyc_q + 2'h1;
    timer_d = timer_q;
    if (wr_timer) begin
      timer_d = REG_WDATA;
    end else if (timer_inc) begin
      timer_d = timer_q + 8'h01;
    end
    wdt_d = wdt_q;
    // a disabled watchdog holds at zero so enabling starts a full period
    if (wdt_clear || !wdt_on || wdt_timeout) begin
      wdt_d = '0;
    end else if (wdt_inc) begin
      wdt_d = wdt_q + twi_pkg::WDT_CNT_W'(1);
    end
    wdt_rst_d = wdt_timeout;
    pwr_d = pwr_q;
    wake_d = 1'b0;
    vec_d = vec_q;
    case (pwr_q)
      twi_pkg::ST_RUN: begin
        if (INSTR_SLEEP) begin
          pwr_d = twi_pkg::ST_SLEEP;
        end
      end
      twi_pkg::ST_SLEEP: begin
        if (p6_change && mask_q[twi_pkg::IRQ_PIN_CHANGE_BIT]) begin
          pwr_d = twi_pkg::ST_RUN;
          wake_d = 1'b1;
          vec_d = glob_q;
        end
      end
      default: pwr_d = twi_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      cyc_q <= 2'h0;
      timer_q <= twi_pkg::TIMER_COUNT_RESET;
      wdt_q <= '0;
      wdt_rst_q <= 1'b0;
      pwr_q <= twi_pkg::ST_RUN;
      wake_q <= 1'b0;
      vec_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      timer_q <= timer_d;
      wdt_q <= wdt_d;
      wdt_rst_q <= wdt_rst_d;
      pwr_q <= pwr_d;
      wake_q <= wake_d;
      vec_q <= vec_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers, flags and read port
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      // the global bit is only moved by instructions and the interrupt acknowledge
      ctrl_d = {REG_WDATA[7], 1'b0, REG_WDATA[5:0]};
    end
    wde_d = wr_wdc ? REG_WDATA[twi_pkg::WDC_ENABLE_BIT] : wde_q;
    // the watchdog comes back enabled after a pin-change wake
    if (wake_q) begin
      wde_d = 1'b1;
    end
    xsel_d = wr_wdc ? REG_WDATA[twi_pkg::WDC_EXT_SEL_BIT] : xsel_q;
    roe_d = wr_wdc ? REG_WDATA[twi_pkg::WDC_ROPT_BIT] : roe_q;
    mask_d = wr_mask ? REG_WDATA[2:0] : mask_q;
    glob_d = glob_q;
    if (INSTR_GLOBAL_OFF || IRQ_ACK) begin
      glob_d = 1'b0;
    end else if (INSTR_GLOBAL_ON) begin
      glob_d = 1'b1;
    end
    flag_set[twi_pkg::IRQ_OVERFLOW_BIT] = timer_inc && !wr_timer && (timer_q == 8'hFF);
    flag_set[twi_pkg::IRQ_PIN_CHANGE_BIT] = p6_change;
    flag_set[twi_pkg::IRQ_EXT_BIT] = xsel_q && ext_fall;
    // firmware can only clear; a new event in the same cycle survives
    flag_d = (wr_flag ? (flag_q & REG_WDATA[2:0]) : flag_q) | flag_set;
    p6_ref_d = rd_port6 ? p6_s : p6_ref_q;
    ropt_d = roe_q ? opt_s : 2'h0;
    rdata_d = rdata_q;
    if (REG_RD) begin
      if (REG_SEL == twi_pkg::SEL_TIMER_COUNT) begin
        rdata_d = timer_q;
      end else if (REG_SEL == twi_pkg::SEL_PORT6_DATA) begin
        rdata_d = p6_s;
      end else if (REG_SEL == twi_pkg::SEL_PRESCALER) begin
        rdata_d = pre_count;
      end else if (REG_SEL == twi_pkg::SEL_TIMER_CTRL) begin
        rdata_d = {ctrl_q[7], glob_q, ctrl_q[5:0]};
      end else if (REG_SEL == twi_pkg::SEL_WATCHDOG_CTRL) begin
        rdata_d = {wde_q, xsel_q, 1'b0, roe_q, 4'h0};
      end else if (REG_SEL == twi_pkg::SEL_IRQ_FLAG) begin
        rdata_d = {5'h00, flag_q & mask_q};
      end else if (REG_SEL == twi_pkg::SEL_IRQ_MASK) begin
        rdata_d = {5'h00, mask_q};
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_q <= twi_pkg::TIMER_CTRL_RESET;
      wde_q <= 1'b1;
      xsel_q <= 1'b0;
      roe_q <= 1'b0;
      mask_q <= twi_pkg::IRQ_RESET;
      glob_q <= 1'b0;
      flag_q <= twi_pkg::IRQ_RESET;
      p6_ref_q <= 8'h00;
      ropt_q <= 2'h0;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      wde_q <= wde_d;
      xsel_q <= xsel_d;
      roe_q <= roe_d;
      mask_q <= mask_d;
      glob_q <= glob_d;
      flag_q <= flag_d;
      p6_ref_q <= p6_ref_d;
      ropt_q <= ropt_d;
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA = rdata_q;
  assign IRQ_REQ = glob_q && |(flag_q & mask_q);
  assign WDT_RESET_REQ = wdt_rst_q;
  assign WAKE_PULSE = wake_q;
  assign WAKE_TO_VECTOR = vec_q;
  assign SLEEPING = (pwr_q == twi_pkg::ST_SLEEP);
  assign PORT6_PIN0_IRQ_MODE = xsel_q;
  assign ROPT_ACTIVE = roe_q;
  assign ROPT_LEVEL = ropt_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  a_flag_read_and: assert property (
    REG_RD && REG_SEL == twi_pkg::SEL_IRQ_FLAG |=> REG_RDATA == {5'h00, $past(flag_q & mask_q)})
    else $error("flag read is not flags and mask");
  a_wdc_unused_zero: assert property (
    REG_RD && REG_SEL == twi_pkg::SEL_WATCHDOG_CTRL |=> REG_RDATA[5] == 1'b0 && REG_RDATA[3:0] == 4'h0)
    else $error("unused watchdog control bits read nonzero");
  a_global_gates_irq: assert property (
    INSTR_GLOBAL_OFF |=> !IRQ_REQ)
    else $error("interrupt request with global enable off");
  a_ext_blocked: assert property (
    $rose(flag_q[twi_pkg::IRQ_EXT_BIT]) |-> $past(xsel_q))
    else $error("external flag set while path blocked");
  a_wdt_off_silent: assert property (
    !wde_q ##1 !wde_q |-> !WDT_RESET_REQ)
    else $error("watchdog reset while disabled");
  a_wdt_clear_pair: assert property (
    (INSTR_WDT_CLEAR || INSTR_SLEEP) && to_wdt |=> wdt_q == '0 && pre_count == 8'hFF)
    else $error("watchdog clear missed counter or prescaler");
  a_timer_wrap: assert property (
    timer_inc && !wr_timer && timer_q == 8'hFF |=> timer_q == 8'h00 && flag_q[0])
    else $error("timer wrap without overflow flag");
  a_cycle_spacing: assert property (
    cyc_tick |=> !cyc_tick)
    else $error("instruction cycle shorter than two clocks");
  a_wake_vector: assert property (
    $rose(WAKE_PULSE) |-> WAKE_TO_VECTOR == $past(glob_q))
    else $error("wake vector does not follow global enable");
  a_ropt_off_zero: assert property (
    !roe_q |=> ROPT_LEVEL == 2'h0)
    else $error("option level shown while disabled");

endmodule

// File: testbench/testbench.sv
// self-checking bench for the timer / watchdog / interrupt control block
// assumes the register port and instruction strobes of twi_timer_watchdog; one clock
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] reg_sel = 3'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [4:0] instr = 5'h00;
  logic timer_pin = 1'b0;
  logic wdt_osc = 1'b0;
  logic [7:0] port6_pin = 8'h00;
  logic [1:0] option_pin = 2'h0;
  logic div4 = 1'b0;
  logic hw_opt = 1'b1;
  logic irq_req;
  logic wdt_rst;
  logic wake_pulse;
  logic wake_vec;
  logic sleeping;
  logic pin0_irq;
  logic ropt_act;
  logic [1:0] ropt_lvl;
  logic wdt_run = 1'b0;
  logic [1:0] osc_div = 2'h0;
  int error_cnt = 0;
  int samples_checked = 0;
  int wdt_pulses = 0;
  int seed = 43;
  // behavioural copy of the two control registers
  int mdl_wdc = 'h80;
  int mdl_mask = 0;
  logic [7:0] v;
  logic [7:0] p;
  logic [2:0] rsel [7] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
  logic [7:0] rexp [7] = '{8'h00, 8'hFF, 8'hBF, 8'h80, 8'h00, 8'h00, 8'h00};

  twi_timer_watchdog #(.WDT_BASE_TICKS(8)) i_twi_timer_watchdog (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .REG_SEL(reg_sel), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .INSTR_GLOBAL_ON(instr[0]), .INSTR_GLOBAL_OFF(instr[1]), .INSTR_WDT_CLEAR(instr[2]),
    .INSTR_SLEEP(instr[3]), .IRQ_ACK(instr[4]), .TIMER_PIN(timer_pin), .WDT_OSC(wdt_osc),
    .PORT6_PIN(port6_pin), .OPTION_PIN(option_pin), .HW_WDT_OPTION(hw_opt),
    .CYCLE_DIV4_OPT(div4), .IRQ_REQ(irq_req), .WDT_RESET_REQ(wdt_rst),
    .WAKE_PULSE(wake_pulse), .WAKE_TO_VECTOR(wake_vec), .SLEEPING(sleeping),
    .PORT6_PIN0_IRQ_MODE(pin0_irq), .ROPT_ACTIVE(ropt_act), .ROPT_LEVEL(ropt_lvl));

  always #25 clk_sys = ~clk_sys;
  // watchdog oscillator: period of 8 system clocks, idle while not needed
  always @(posedge clk_sys) begin
    if (wdt_run) begin
      osc_div <= osc_div + 2'h1;
      if (osc_div == 2'h3) wdt_osc <= ~wdt_osc;
    end
  end
  always @(negedge clk_sys) begin
    if (wdt_rst === 1'b1) wdt_pulses++;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // counts whose phase against the cycle divider is not fixed get a window
  task automatic near(input logic [7:0] got, input int lo, input int hi);
    samples_checked++;
    if ($isunknown(got) || got < lo || got > hi) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo[7:0], hi[7:0]);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk_sys);
    reg_sel <= s;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // unused bits never stick in the model
    if (s == twi_pkg::SEL_WATCHDOG_CTRL) mdl_wdc = d & 8'hD0;
    if (s == twi_pkg::SEL_IRQ_MASK) mdl_mask = d & 8'h07;
  endtask
  task automatic rd(input logic [2:0] s, output logic [7:0] d);
    @(posedge clk_sys);
    reg_sel <= s;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic chk_model(input logic [2:0] s);
    rd(s, v);
    chk(v, 8'(s == twi_pkg::SEL_IRQ_MASK ? mdl_mask : mdl_wdc));
  endtask
  task automatic op(input int k);
    @(posedge clk_sys);
    instr[k] <= 1'b1;
    @(posedge clk_sys);
    instr[k] <= 1'b0;
  endtask
  task automatic do_reset;
    reset_n <= 1'b0;
    cyc(20);
    reset_n <= 1'b1;
    mdl_wdc = 'h80;
    mdl_mask = 0;
    cyc(3);
  endtask
  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, error_cnt);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (int d = 1; d >= 0; d--) begin
      div4 <= d[0];
      do_reset;
      wr(twi_pkg::SEL_TIMER_CTRL, 8'h08);
      wr(twi_pkg::SEL_TIMER_COUNT, 8'h00);
      cyc(40);
      rd(twi_pkg::SEL_TIMER_COUNT, v);
      near(v, 42 / (2 * (d + 1)) - 2, 42 / (2 * (d + 1)) + 2);
    end
    done("timer rate");
    do_reset;
    for (int i = 0; i < 7; i++) begin
      rd(rsel[i], v);
      chk(v, rexp[i]);
    end
    done("reset values");
    wr(twi_pkg::SEL_WATCHDOG_CTRL, 8'hFF);
    rd(twi_pkg::SEL_WATCHDOG_CTRL, v);
    chk(v, 8'hD0);
    wr(twi_pkg::SEL_IRQ_MASK, 8'hFF);
    rd(twi_pkg::SEL_IRQ_MASK, v);
    chk(v, 8'h07);
    wr(twi_pkg::SEL_IRQ_MASK, 8'($random(seed)));
    chk_model(twi_pkg::SEL_IRQ_MASK);
    wr(twi_pkg::SEL_IRQ_MASK, 8'h00);
    option_pin <= 2'($random(seed));
    cyc(5);
    chk({7'h00, pin0_irq}, 8'h01);
    chk({7'h00, ropt_act}, 8'h01);
    chk({6'h00, ropt_lvl}, {6'h00, option_pin});
    wr(twi_pkg::SEL_WATCHDOG_CTRL, 8'h00);
    cyc(3);
    chk({6'h00, ropt_lvl, ropt_act, pin0_irq}, 8'h00);
    chk_model(twi_pkg::SEL_WATCHDOG_CTRL);
    done("control registers");
    for (int s = 0; s < 3; s++) begin
      wr(twi_pkg::SEL_TIMER_CTRL, 8'(s));
      wr(twi_pkg::SEL_TIMER_COUNT, 8'h00);
      rd(twi_pkg::SEL_PRESCALER, v);
      near(v, 8'hFD, 8'hFF);
      cyc(160);
      rd(twi_pkg::SEL_TIMER_COUNT, v);
      near(v, 165 / (4 << s) - 2, 165 / (4 << s) + 2);
    end
    done("timer prescaler");
    for (int e = 0; e < 2; e++) begin
      wr(twi_pkg::SEL_TIMER_CTRL, e ? 8'h38 : 8'h28);
      wr(twi_pkg::SEL_TIMER_COUNT, 8'h00);
      repeat (5) begin
        @(posedge clk_sys) timer_pin <= 1'b1;
        cyc(4);
        timer_pin <= 1'b0;
        cyc(4);
      end
      cyc(6);
      rd(twi_pkg::SEL_TIMER_COUNT, v);
      chk(v, 8'h05);
    end
    done("external count");
    wr(twi_pkg::SEL_TIMER_CTRL, 8'h08);
    wr(twi_pkg::SEL_TIMER_COUNT, 8'hFE);
    cyc(10);
    wr(twi_pkg::SEL_IRQ_MASK, 8'h01);
    rd(twi_pkg::SEL_IRQ_FLAG, v);
    chk(v, 8'h01);
    chk({7'h00, irq_req}, 8'h00);
    op(0);
    cyc(1);
    chk({7'h00, irq_req}, 8'h01);
    op(4);
    cyc(1);
    chk({7'h00, irq_req}, 8'h00);
    op(0);
    op(1);
    cyc(1);
    chk({7'h00, irq_req}, 8'h00);
    wr(twi_pkg::SEL_IRQ_FLAG, 8'h00);
    wr(twi_pkg::SEL_IRQ_FLAG, 8'hFF);
    rd(twi_pkg::SEL_IRQ_FLAG, v);
    chk(v, 8'h00);
    done("overflow and global enable");
    for (int m = 0; m < 4; m++) begin
      wr(twi_pkg::SEL_TIMER_CTRL, m == 3 ? 8'h09 : 8'h00);
      wr(twi_pkg::SEL_WATCHDOG_CTRL, m == 1 ? 8'h00 : 8'h80);
      wdt_run <= 1'b1;
      op(2);
      if (m == 3) begin
        rd(twi_pkg::SEL_PRESCALER, v);
        near(v, 8'hFE, 8'hFF);
      end
      wdt_pulses = 0;
      for (int k = 0; k < 7; k++) begin
        cyc(32);
        if (m == 2) op(2);
      end
      chk(8'(wdt_pulses), m == 0 ? 8'h03 : (m == 3 ? 8'h01 : 8'h00));
    end
    wdt_run <= 1'b0;
    done("watchdog");
    for (int g = 1; g >= 0; g--) begin
      wr(twi_pkg::SEL_WATCHDOG_CTRL, 8'h00);
      p = 8'($random(seed));
      port6_pin <= p;
      cyc(4);
      rd(twi_pkg::SEL_PORT6_DATA, v);
      chk(v, p);
      wr(twi_pkg::SEL_IRQ_FLAG, 8'h00);
      wr(twi_pkg::SEL_IRQ_MASK, 8'h02);
      op(g ? 0 : 1);
      op(3);
      cyc(2);
      chk({7'h00, sleeping}, 8'h01);
      port6_pin <= p ^ 8'h10;
      v = 8'h00;
      for (int i = 0; i < 20 && v == 8'h00; i++) begin
        @(negedge clk_sys);
        if (wake_pulse === 1'b1) v = {7'h00, wake_vec} | 8'h80;
      end
      chk(v, {7'h40, g[0]} | 8'h80);
      cyc(1);
      chk({7'h00, sleeping}, 8'h00);
    end
    op(1);
    done("pin change wake");
    for (int s = 1; s >= 0; s--) begin
      wr(twi_pkg::SEL_WATCHDOG_CTRL, s ? 8'h40 : 8'h00);
      wr(twi_pkg::SEL_IRQ_MASK, 8'h04);
      @(posedge clk_sys) port6_pin[0] <= 1'b1;
      cyc(5);
      port6_pin[0] <= 1'b0;
      cyc(5);
      rd(twi_pkg::SEL_IRQ_FLAG, v);
      chk(v, s ? 8'h04 : 8'h00);
      wr(twi_pkg::SEL_IRQ_FLAG, 8'h00);
    end
    done("external interrupt");
    stop_test;
  end
endmodule
